// ---- hw/dctm_pkg.sv ----
/*
 * Shared constants and types for the dual-channel temperature monitor core:
 * register pointer values, reset values, bit positions, bus offsets, timing.
 * Assumes a 25 MHz core clock and an AXI4-Lite master with 32-bit data.
 */
package dctm_pkg;
    // pointer values of the byte registers (reads and writes use different ones)
    localparam logic [7:0] RD_LOCAL = 8'h00;
    localparam logic [7:0] RD_REMOTE = 8'h01;
    localparam logic [7:0] RD_STATUS = 8'h02;
    localparam logic [7:0] RD_CONFIG = 8'h03;
    localparam logic [7:0] RD_RATE = 8'h04;
    localparam logic [7:0] RD_LOCAL_HI = 8'h05;
    localparam logic [7:0] RD_LOCAL_LO = 8'h06;
    localparam logic [7:0] RD_REMOTE_HI = 8'h07;
    localparam logic [7:0] RD_REMOTE_LO = 8'h08;
    localparam logic [7:0] WR_CONFIG = 8'h09;
    localparam logic [7:0] WR_RATE = 8'h0A;
    localparam logic [7:0] WR_LOCAL_HI = 8'h0B;
    localparam logic [7:0] WR_LOCAL_LO = 8'h0C;
    localparam logic [7:0] WR_REMOTE_HI = 8'h0D;
    localparam logic [7:0] WR_REMOTE_LO = 8'h0E;
    localparam logic [7:0] WR_ONE_SHOT = 8'h0F;
    localparam logic [7:0] RD_MAKER_ID = 8'hFE;
    localparam logic [7:0] RD_REVISION = 8'hFF;

    // reset values and the answer to a read of a non-readable pointer
    localparam logic [7:0] VALUE_RST = 8'h80;
    localparam logic [7:0] CONFIG_RST = 8'h00;
    localparam logic [7:0] RATE_RST = 8'h02;
    localparam logic [7:0] HIGH_LIMIT_RST = 8'h7F;
    localparam logic [7:0] LOW_LIMIT_RST = 8'hC9;
    localparam logic [7:0] POINTER_RST = 8'h00;
    localparam logic [7:0] INVALID_READ = 8'hFF;

    // field positions
    localparam int STAT_BUSY = 7;
    localparam int CFG_MASK = 7;
    localparam int CFG_STOP = 6;
    localparam int RATE_W = 3;
    localparam logic [2:0] RATE_FASTEST = 3'h7;

    // averaging: sixteen samples per channel
    localparam int AVG_COUNT = 16;
    localparam logic [3:0] AVG_LAST = 4'(AVG_COUNT - 1);

    // AXI4-Lite byte offsets and command word layout
    localparam int AXI_ADDR_W = 8;
    localparam logic [7:0] AXI_CMD = 8'h00;
    localparam logic [7:0] AXI_DATA = 8'h04;
    localparam logic [7:0] AXI_ALERT_RESP = 8'h08;
    localparam int CMD_DATA_LSB = 8;
    localparam int CMD_HAS_DATA = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // conversion pacing at the fastest rate code
    localparam int CLK_KHZ = 25000;
    localparam int FAST_CONV_MS = 125;
    localparam int FAST_CONV_CYC = FAST_CONV_MS * CLK_KHZ;

    // one result from the measurement front end
    typedef struct packed {
        logic open;
        logic [7:0] code;
    } dctm_sample_t;

    // limit and sensor flags in status bit order 6 down to 2
    typedef struct packed {
        logic local_high;
        logic local_low_flag;
        logic remote_high;
        logic remote_low_flag;
        logic open;
    } dctm_flags_t;
endpackage : dctm_pkg

// ---- hw/dctm_core.sv ----
/*
 * Digital core of a two-channel temperature monitor: conversion sequencing,
 * sixteen-sample averaging, limit compare, status flags, alarm output and the
 * pointer-addressed byte register file behind an AXI4-Lite slave.
 * Assumes a front end that returns one signed sample per start pulse and a
 * synchronous standby pin; all inputs are synchronous to mclk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module dctm_core #(
    parameter int unsigned FAST_PERIOD_CYC = dctm_pkg::FAST_CONV_CYC,
    parameter logic [6:0] DEV_ADDR = 7'h2A, // arbitrary value
    parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
    parameter logic [3:0] PART_ID = 4'h6, // arbitrary value
    parameter logic [3:0] DIE_REV = 4'h1 // arbitrary value
) (
    // clock, reset, enable
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // AXI4-Lite write channels
    input wire logic [dctm_pkg::AXI_ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read channels
    input wire logic [dctm_pkg::AXI_ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // measurement front end
    output logic meas_start_o,
    output logic meas_remote_o,
    input wire logic sample_valid_i,
    input wire dctm_pkg::dctm_sample_t sample_i,
    // pins
    input wire logic standby_in_n_i,
    output logic alert_n_o
);

    typedef enum logic [2:0] {
        ST_IDLE, ST_ISSUE, ST_WAIT, ST_STORE, ST_COMPARE
    } dctm_conv_state_t;

    // signed compares shared by both channels
    function automatic logic above(input logic [7:0] val, input logic [7:0] lim);
        above = $signed(val) > $signed(lim);
    endfunction : above

    function automatic logic below(input logic [7:0] val, input logic [7:0] lim);
        below = $signed(val) < $signed(lim);
    endfunction : below

    // mean of sixteen, floored at zero since the sensor cannot read negative
    function automatic logic [7:0] avg_clamp(input logic [11:0] sum);
        avg_clamp = sum[11] ? 8'h00 : sum[11:4];
    endfunction : avg_clamp

    // register file
    logic [7:0] local_value;
    logic [7:0] remote_value;
    logic [7:0] cfg;
    logic [7:0] rate;
    logic [7:0] local_hi;
    logic [7:0] local_lo;
    logic [7:0] remote_hi;
    logic [7:0] remote_lo;
    logic [7:0] pointer;
    dctm_pkg::dctm_flags_t flags;
    logic alarm_latch;

    // conversion engine
    dctm_conv_state_t state;
    logic boot;
    logic one_shot;
    logic chan_remote;
    logic [3:0] avg_cnt;
    logic [11:0] acc;
    logic [7:0] local_avg;
    logic open_seen;
    logic open_acc;
    logic [31:0] timer;

    // bus holding registers
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // pacing and run control
    wire stopped = cfg[dctm_pkg::CFG_STOP] | ~standby_in_n_i;
    wire [31:0] period = 32'(FAST_PERIOD_CYC) << (dctm_pkg::RATE_FASTEST - rate[2:0]);
    wire timer_due = timer >= period - 32'h1;
    wire in_idle = state == ST_IDLE;
    wire start_conv = in_idle & ((boot & ~stopped) | one_shot | (timer_due & ~stopped));
    wire boot_compare = in_idle & boot & stopped & ~one_shot;
    wire compare_evt = state == ST_COMPARE;
    wire busy = (state == ST_ISSUE) | (state == ST_WAIT) | (state == ST_STORE);
    wire take_sample = (state == ST_WAIT) & sample_valid_i;
    wire last_sample = take_sample & (avg_cnt == dctm_pkg::AVG_LAST);
    wire [11:0] next_acc = acc + {{4{sample_i.code[7]}}, sample_i.code};

    // live limit conditions on the stored values
    dctm_pkg::dctm_flags_t live;
    assign live.local_high = above(local_value, local_hi);
    assign live.local_low_flag = below(local_value, local_lo);
    assign live.remote_high = above(remote_value, remote_hi);
    assign live.remote_low_flag = below(remote_value, remote_lo);
    assign live.open = open_seen;

    // bus handshakes; a write fires once both address and data are held
    wire wr_fire = aw_got & w_got & ~s_axi_bvalid_o;
    wire rd_fire = s_axi_arvalid_i & s_axi_arready_o;
    wire wr_cmd = wr_fire & (aw_addr == dctm_pkg::AXI_CMD) & w_strb[0];
    wire wr_map_ok = (aw_addr == dctm_pkg::AXI_CMD);
    wire [7:0] wr_ptr = w_data[7:0];
    wire wr_byte = wr_cmd & w_data[dctm_pkg::CMD_HAS_DATA] & w_strb[1];
    wire [7:0] wr_val = w_data[dctm_pkg::CMD_DATA_LSB +: 8];
    wire we_cfg = wr_byte & (wr_ptr == dctm_pkg::WR_CONFIG);
    wire we_rate = wr_byte & (wr_ptr == dctm_pkg::WR_RATE);
    wire we_lhi = wr_byte & (wr_ptr == dctm_pkg::WR_LOCAL_HI);
    wire we_llo = wr_byte & (wr_ptr == dctm_pkg::WR_LOCAL_LO);
    wire we_rhi = wr_byte & (wr_ptr == dctm_pkg::WR_REMOTE_HI);
    wire we_rlo = wr_byte & (wr_ptr == dctm_pkg::WR_REMOTE_LO);
    wire we_shot = wr_byte & (wr_ptr == dctm_pkg::WR_ONE_SHOT);

    // read selection by the held pointer; write-only pointers read invalid
    wire [7:0] status_byte = {busy, flags, 2'h0};
    wire [7:0] ptr_byte =
        (pointer == dctm_pkg::RD_LOCAL) ? local_value :
        (pointer == dctm_pkg::RD_REMOTE) ? remote_value :
        (pointer == dctm_pkg::RD_STATUS) ? status_byte :
        (pointer == dctm_pkg::RD_CONFIG) ? cfg :
        (pointer == dctm_pkg::RD_RATE) ? rate :
        (pointer == dctm_pkg::RD_LOCAL_HI) ? local_hi :
        (pointer == dctm_pkg::RD_LOCAL_LO) ? local_lo :
        (pointer == dctm_pkg::RD_REMOTE_HI) ? remote_hi :
        (pointer == dctm_pkg::RD_REMOTE_LO) ? remote_lo :
        (pointer == dctm_pkg::RD_MAKER_ID) ? MAKER_ID :
        (pointer == dctm_pkg::RD_REVISION) ? {PART_ID, DIE_REV} :
        dctm_pkg::INVALID_READ;
    wire rd_data_sel = s_axi_araddr_i == dctm_pkg::AXI_DATA;
    wire rd_cmd_sel = s_axi_araddr_i == dctm_pkg::AXI_CMD;
    wire rd_ara_sel = s_axi_araddr_i == dctm_pkg::AXI_ALERT_RESP;
    wire [31:0] rd_word =
        rd_data_sel ? {24'h000000, ptr_byte} :
        rd_cmd_sel ? {24'h000000, pointer} :
        rd_ara_sel ? {24'h000000, DEV_ADDR, 1'h1} : 32'h00000000;
    wire rd_ok = rd_data_sel | rd_cmd_sel | rd_ara_sel;
    wire status_rd = rd_fire & rd_data_sel & (pointer == dctm_pkg::RD_STATUS);
    wire service_rd = status_rd | (rd_fire & rd_ara_sel);

    // flags: compare sets, status read clears only vanished ones; set wins
    wire [4:0] flag_set = compare_evt ? live : 5'h00;
    wire [4:0] flag_clr = status_rd ? ~live : 5'h00;
    wire [4:0] next_flags = flag_set | (flags & ~flag_clr);
    // latch follows any flag; released by a service read once all is clean
    wire next_alarm = (|next_flags) |
        (alarm_latch & ~(service_rd & ~(|next_flags) & ~(|live)));

    // AXI4-Lite write side
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            s_axi_awready_o <= 1'h1;
            s_axi_wready_o <= 1'h1;
            s_axi_bvalid_o <= 1'h0;
            s_axi_bresp_o <= dctm_pkg::RESP_OKAY;
            aw_got <= 1'h0;
            w_got <= 1'h0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else if (ce_i) begin
            if (s_axi_awvalid_i & s_axi_awready_o) begin
                aw_addr <= s_axi_awaddr_i;
                aw_got <= 1'h1;
                s_axi_awready_o <= 1'h0;
            end
            if (s_axi_wvalid_i & s_axi_wready_o) begin
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
                w_got <= 1'h1;
                s_axi_wready_o <= 1'h0;
            end
            if (wr_fire) begin
                s_axi_bvalid_o <= 1'h1;
                s_axi_bresp_o <= wr_map_ok ? dctm_pkg::RESP_OKAY : dctm_pkg::RESP_SLVERR;
            end
            // channels reopen only after the response is taken
            if (s_axi_bvalid_o & s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'h0;
                aw_got <= 1'h0;
                w_got <= 1'h0;
                s_axi_awready_o <= 1'h1;
                s_axi_wready_o <= 1'h1;
            end
        end
    end

    // AXI4-Lite read side; one read in flight
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            s_axi_arready_o <= 1'h1;
            s_axi_rvalid_o <= 1'h0;
            s_axi_rdata_o <= 32'h00000000;
            s_axi_rresp_o <= dctm_pkg::RESP_OKAY;
        end else if (ce_i) begin
            if (rd_fire) begin
                s_axi_arready_o <= 1'h0;
                s_axi_rvalid_o <= 1'h1;
                s_axi_rdata_o <= rd_word;
                s_axi_rresp_o <= rd_ok ? dctm_pkg::RESP_OKAY : dctm_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid_o & s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'h0;
                s_axi_arready_o <= 1'h1;
            end
        end
    end

    // pointer and host-writable registers; read-only pointers ignore writes
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            pointer <= dctm_pkg::POINTER_RST;
            cfg <= dctm_pkg::CONFIG_RST;
            rate <= dctm_pkg::RATE_RST;
            local_hi <= dctm_pkg::HIGH_LIMIT_RST;
            local_lo <= dctm_pkg::LOW_LIMIT_RST;
            remote_hi <= dctm_pkg::HIGH_LIMIT_RST;
            remote_lo <= dctm_pkg::LOW_LIMIT_RST;
        end else if (ce_i) begin
            if (wr_cmd) pointer <= wr_ptr;
            if (we_cfg) cfg <= wr_val;
            if (we_rate) rate <= wr_val;
            if (we_lhi) local_hi <= wr_val;
            if (we_llo) local_lo <= wr_val;
            if (we_rhi) remote_hi <= wr_val;
            if (we_rlo) remote_lo <= wr_val;
        end
    end

    // flags, alarm latch and masked alarm pin (one cycle behind the latch)
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            flags <= 5'h00;
            alarm_latch <= 1'h0;
            alert_n_o <= 1'h1;
        end else if (ce_i) begin
            flags <= next_flags;
            alarm_latch <= next_alarm;
            alert_n_o <= ~(alarm_latch & ~cfg[dctm_pkg::CFG_MASK]);
        end
    end

    // pacing timer restarts at every conversion start
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            timer <= 32'h00000000;
            one_shot <= 1'h0;
            boot <= 1'h1;
        end else if (ce_i) begin
            if (start_conv) timer <= 32'h00000000;
            else if (!timer_due) timer <= timer + 32'h1;
            // a one-shot runs even in standby; set wins over the start
            one_shot <= we_shot | (one_shot & ~start_conv);
            if (in_idle) boot <= 1'h0;
        end
    end

    // conversion sequence: local then remote, sixteen samples each
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            state <= ST_IDLE;
            chan_remote <= 1'h0;
            avg_cnt <= 4'h0;
            acc <= 12'h000;
            local_avg <= dctm_pkg::VALUE_RST;
            local_value <= dctm_pkg::VALUE_RST;
            remote_value <= dctm_pkg::VALUE_RST;
            open_acc <= 1'h0;
            open_seen <= 1'h0;
            meas_start_o <= 1'h0;
            meas_remote_o <= 1'h0;
        end else if (ce_i) begin
            meas_start_o <= 1'h0;
            case (state)
                ST_IDLE: begin
                    if (start_conv) begin
                        chan_remote <= 1'h0;
                        avg_cnt <= 4'h0;
                        acc <= 12'h000;
                        open_acc <= 1'h0;
                        state <= ST_ISSUE;
                    end else if (boot_compare) begin
                        state <= ST_COMPARE;
                    end
                end
                ST_ISSUE: begin
                    meas_start_o <= 1'h1;
                    meas_remote_o <= chan_remote;
                    state <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (take_sample) begin
                        acc <= next_acc;
                        avg_cnt <= avg_cnt + 4'h1;
                        open_acc <= open_acc | (chan_remote & sample_i.open);
                        state <= ST_ISSUE;
                    end
                    if (last_sample) begin
                        avg_cnt <= 4'h0;
                        if (chan_remote) begin
                            state <= ST_STORE;
                        end else begin
                            acc <= 12'h000; // remote sum must survive until the store
                            local_avg <= avg_clamp(next_acc);
                            chan_remote <= 1'h1;
                        end
                    end
                end
                ST_STORE: begin
                    // both channels land together, then compare
                    local_value <= local_avg;
                    remote_value <= avg_clamp(acc);
                    open_seen <= open_acc;
                    state <= ST_COMPARE;
                end
                ST_COMPARE: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule : dctm_core

`default_nettype wire

// ---- bench/dctm_core_asserts.sv ----
/*
 * Port-level checker for dctm_core: bus answers, refusals, sampling order.
 * Assumes binding into dctm_core with ports connected by name.
 */
`timescale 1ns/1ps
`default_nettype none

module dctm_core_asserts (
    // clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // write channels
    input wire logic [dctm_pkg::AXI_ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // read channels
    input wire logic [dctm_pkg::AXI_ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // front end and pin
    input wire logic meas_start_o,
    input wire logic meas_remote_o,
    input wire logic alert_n_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    logic [4:0] n_local;
    wire aw_w_hs = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    wire ar_hs = s_axi_arvalid_i && s_axi_arready_o;
    wire ar_bad = !(s_axi_araddr_i inside {8'h00, 8'h04, 8'h08});

    // local samples since the last remote one; saturates so a stuck mux shows
    always_ff @(posedge mclk_i) begin
        if (!resetn_i || (meas_start_o && meas_remote_o)) begin
            n_local <= 5'h00;
        end else if (meas_start_o && n_local != 5'h1F) begin
            n_local <= n_local + 5'h01;
        end
    end

    a_write_answer: assert property (aw_w_hs |=> !s_axi_awready_o ##1 s_axi_bvalid_o)
        else $error("write not answered in two cycles");
    a_write_refused: assert property (aw_w_hs && s_axi_awaddr_i != dctm_pkg::AXI_CMD
        |=> ##1 s_axi_bresp_o == dctm_pkg::RESP_SLVERR)
        else $error("bad write address not refused");
    a_bresp_held: assert property (s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped early");
    a_read_answer: assert property (ar_hs |=> s_axi_rvalid_o && !s_axi_arready_o)
        else $error("read not answered in one cycle");
    a_read_refused: assert property (ar_hs && ar_bad
        |=> s_axi_rresp_o == dctm_pkg::RESP_SLVERR && s_axi_rdata_o == 32'h0)
        else $error("bad read address not refused");
    a_rdata_held: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data changed while waiting");
    a_start_single: assert property (meas_start_o |=> !meas_start_o)
        else $error("start request longer than one cycle");
    a_local_first: assert property ($rose(meas_remote_o) |-> n_local == 5'h10)
        else $error("remote channel selected before sixteen local samples");

    c_write: cover property (aw_w_hs);
    c_remote: cover property ($rose(meas_remote_o));
    c_alarm: cover property ($fell(alert_n_o));
endmodule : dctm_core_asserts

`default_nettype wire

// ---- bench/dctm_front_model.sv ----
/*
 * Behavioural measurement front end: answers each start after DELAY cycles.
 * Alternates code and code+1 so averaging is visible; data moves when idle.
 */
`timescale 1ns/1ps
`default_nettype none

module dctm_front_model #(
    parameter int DELAY = 10
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // requests from the core
    input wire logic start_i,
    input wire logic remote_i,
    // codes the sensors report
    input wire logic [7:0] local_code_i,
    input wire logic [7:0] remote_code_i,
    // answer to the core
    output logic valid_o,
    output dctm_pkg::dctm_sample_t sample_o
);
    logic [7:0] cnt;
    logic rem;
    logic odd;

    // sample outside its pulse toggles between the last good value and its inverse
    always_ff @(posedge mclk_i) begin
        valid_o <= 1'b0;
        sample_o <= ~sample_o;
        if (!resetn_i) begin
            cnt <= 8'h00;
            odd <= 1'b0;
            sample_o <= '0;
        end else if (start_i) begin
            cnt <= 8'(DELAY);
            rem <= remote_i;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
            if (cnt == 8'h01) begin
                valid_o <= 1'b1;
                odd <= ~odd;
                sample_o <= {1'b0, (rem ? remote_code_i : local_code_i) + {7'h00, odd}};
            end
        end
    end
endmodule : dctm_front_model

`default_nettype wire

// ---- bench/tb_dctm_core.sv ----
/*
 * Self-checking bench for dctm_core over AXI4-Lite with a front end model.
 * Assumes FAST_PERIOD_CYC shortened to 50 cycles.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_dctm_core;
    logic mclk_i, resetn_i, ce_i, standby_in_n_i, alert_n_o, meas_start_o, meas_remote_o;
    logic [7:0] s_axi_awaddr_i, s_axi_araddr_i, lcode, rcode, v;
    logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
    logic s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
    logic s_axi_rvalid_o, s_axi_rready_i, sample_valid_i;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o, d;
    logic [3:0] s_axi_wstrb_i;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r;
    dctm_pkg::dctm_sample_t sample_i;
    int errors = 0, n_checks = 0, n_starts = 0, cyc = 0, t_prev = 0, t_last = 0, n0;

    dctm_core #(.FAST_PERIOD_CYC(50), .PART_ID(4'h6), .DIE_REV(4'h1)) i_dut (.*);
    dctm_front_model i_fe (.mclk_i(mclk_i), .resetn_i(resetn_i), .start_i(meas_start_o),
        .remote_i(meas_remote_o), .local_code_i(lcode), .remote_code_i(rcode),
        .valid_o(sample_valid_i), .sample_o(sample_i));

    // clock
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    // stamp the first sample request of every conversion
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (meas_start_o) begin
            n_starts <= n_starts + 1;
            if (n_starts % 32 == 0) begin
                t_prev <= t_last;
                t_last <= cyc;
            end
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude

    // both write channels offered together, each released at its own handshake
    task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rs);
        int i;
        @(posedge mclk_i);
        s_axi_awaddr_i <= a;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wdata_i <= dat;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge mclk_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
            if (s_axi_bvalid_o) break;
        end
        if (i == 50) begin
            errors++;
            conclude();
        end
        rs = s_axi_bresp_o;
        s_axi_bready_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rs);
        int i;
        @(posedge mclk_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge mclk_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
            if (s_axi_rvalid_o) break;
        end
        if (i == 50) begin
            errors++;
            conclude();
        end
        dat = s_axi_rdata_o;
        rs = s_axi_rresp_o;
        s_axi_rready_i <= 1'b0;
    endtask : rd

    // byte registers: pointer and data in one command write, or the pointer then a read at it
    task automatic wreg(input logic [7:0] p, input logic [7:0] b);
        wr(8'h00, {15'h0000, 1'b1, b, p}, r);
    endtask : wreg

    task automatic rreg(input logic [7:0] p, output logic [7:0] b);
        wr(8'h00, {24'h000000, p}, r);
        rd(8'h04, d, r);
        b = d[7:0];
    endtask : rreg

    // waits out one conversion; busy must show while it runs
    task automatic wait_conv;
        int t, i;
        t = n_starts + 32;
        for (i = 0; i < 5000 && n_starts < t; i++) @(posedge mclk_i);
        rreg(dctm_pkg::RD_STATUS, v);
        check(32'(v[7]), 32'h1);
        for (i = 0; i < 20 && v[7] !== 1'b0; i++) rreg(dctm_pkg::RD_STATUS, v);
        if (v[7] !== 1'b0 || n_starts < t) begin
            errors++;
            conclude();
        end
    endtask : wait_conv

    // main sequence
    initial begin
        {resetn_i, standby_in_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = '0;
        {s_axi_arvalid_i, s_axi_rready_i, s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
        ce_i = 1'b1;
        s_axi_wstrb_i = 4'hF;
        lcode = 8'h19;
        rcode = 8'hFB;
        repeat (4) @(posedge mclk_i);
        resetn_i <= 1'b1;
        repeat (6) @(posedge mclk_i);
        check(alert_n_o, 1'b0);
        rreg(dctm_pkg::RD_STATUS, v);
        check(v, 8'h28);
        rreg(dctm_pkg::RD_LOCAL, v);
        check(v, 8'h80);
        wreg(dctm_pkg::RD_REMOTE, 8'h11);
        rreg(dctm_pkg::RD_REMOTE, v);
        check(v, 8'h80);
        rreg(dctm_pkg::WR_CONFIG, v);
        check(v, 8'hFF);
        rreg(dctm_pkg::RD_REVISION, v);
        check(v, 8'h61);
        rd(8'h0C, d, r);
        check(r, dctm_pkg::RESP_SLVERR);
        wr(8'h04, 32'h0, r);
        check(r, dctm_pkg::RESP_SLVERR);
        wreg(dctm_pkg::WR_LOCAL_LO, 8'h80);
        wreg(dctm_pkg::WR_REMOTE_LO, 8'h80);
        rreg(dctm_pkg::RD_STATUS, v);
        repeat (3) @(posedge mclk_i);
        check(alert_n_o, 1'b1);
        rreg(dctm_pkg::RD_STATUS, v);
        check(v, 8'h00);
        wreg(dctm_pkg::WR_LOCAL_HI, 8'h14);
        wreg(dctm_pkg::WR_RATE, 8'h03);
        standby_in_n_i <= 1'b1;
        wait_conv();
        rreg(dctm_pkg::RD_LOCAL, v);
        check(v, 8'h19);
        rreg(dctm_pkg::RD_REMOTE, v);
        check(v, 8'h00);
        rreg(dctm_pkg::RD_STATUS, v);
        check(v, 8'h40);
        check(alert_n_o, 1'b0);
        wreg(dctm_pkg::WR_CONFIG, 8'h80);
        repeat (3) @(posedge mclk_i);
        check(alert_n_o, 1'b1);
        wreg(dctm_pkg::WR_CONFIG, 8'h00);
        wreg(dctm_pkg::WR_LOCAL_HI, 8'h7F);
        wait_conv();
        wait_conv();
        check(t_last - t_prev, 800);
        repeat (3) @(posedge mclk_i);
        check(alert_n_o, 1'b1);
        wreg(dctm_pkg::WR_CONFIG, 8'h40);
        lcode <= 8'h3C;
        repeat (900) @(posedge mclk_i);
        n0 = n_starts;
        repeat (1600) @(posedge mclk_i);
        check(n_starts, n0);
        rreg(dctm_pkg::RD_LOCAL, v);
        check(v, 8'h19);
        // one-shot while stopped; positive remote code exercises the remote store
        rcode <= 8'h2D;
        wreg(dctm_pkg::WR_ONE_SHOT, 8'h00);
        wait_conv();
        rreg(dctm_pkg::RD_REMOTE, v);
        check(v, 8'h2D);
        rreg(dctm_pkg::RD_LOCAL, v);
        check(v, 8'h3C);
        conclude();
    end
endmodule : tb_dctm_core

bind dctm_core dctm_core_asserts i_asserts (.*);

`default_nettype wire
